/* core/cal_cfg_pkg.sv */
// Package for the per-channel configuration and calibration register bank.
// Assumes a 16-bit register image carried in the low bits of a 32-bit Avalon-MM word.
package cal_cfg_pkg;

    localparam int unsigned REG_W = 16;

    // Printed offsets are not all multiples of four, so they are register indices.
    localparam logic [5:0] CHAN_A_CONFIG_IDX       = 6'h18;
    localparam logic [5:0] CHAN_A_OFFSET_UPPER_IDX = 6'h19;
    localparam logic [5:0] CHAN_A_OFFSET_LOWER_IDX = 6'h1A;
    localparam logic [5:0] CHAN_A_GAIN_UPPER_IDX   = 6'h1B;
    localparam logic [5:0] CHAN_A_GAIN_LOWER_IDX   = 6'h1C;
    localparam logic [5:0] CHAN_B_CONFIG_IDX       = 6'h1D;
    localparam logic [5:0] STATUS_IDX              = 6'h30;

    localparam logic [15:0] CONFIG_RESET       = 16'h0000;
    localparam logic [15:0] OFFSET_UPPER_RESET = 16'h0000;
    localparam logic [15:0] OFFSET_LOWER_RESET = 16'h0000;
    localparam logic [15:0] GAIN_UPPER_RESET   = 16'h8000;
    localparam logic [15:0] GAIN_LOWER_RESET   = 16'h0000;

    localparam int unsigned PHASE_LSB  = 6;
    localparam int unsigned PHASE_MSB  = 15;
    localparam int unsigned DC_OFF_BIT = 2;
    localparam int unsigned SEL_LSB    = 0;
    localparam int unsigned SEL_MSB    = 1;
    localparam int unsigned CAL_LOW_LSB = 8;

    // Writable bits of each register; the rest read as zero.
    localparam logic [15:0] CONFIG_MASK    = 16'hFFC7;
    localparam logic [15:0] FULL_MASK      = 16'hFFFF;
    localparam logic [15:0] CAL_LOWER_MASK = 16'hFF00;

    typedef enum logic [1:0] {
        SEL_OWN_PINS,
        SEL_SHORTED,
        SEL_POS_TEST,
        SEL_NEG_TEST
    } input_select_t;

    typedef struct packed {
        logic signed [9:0] phase_delay;
        logic              dc_removal_off;
        input_select_t     input_select;
    } chan_config_t;

    typedef struct packed {
        logic signed [23:0] offset;
        logic        [23:0] gain;
    } chan_cal_t;

endpackage

/* core/adc_channel_cal_cfg_regs.sv */
// Configuration registers for two converter channels and calibration registers for the first channel.
// Assumes an Avalon-MM master on the same clock that holds each request until waitrequest is low.
// What this block does
// - The first channel keeps a signed 10-bit phase delay in configuration bits 15:6.
// - The second channel keeps its own phase delay of the same width, place and meaning.
// - Bit 2 of the first configuration word set to one bypasses that channel's DC removal.
// - With that bit at zero the channel follows the global 4-bit DC removal setting.
// - The second channel has its own independent DC removal bypass at bit 2.
// - Bits 1:0 pick own pins, shorted inputs, positive test or negative test signal.
// - The second channel input select uses the same code, own pins after reset.
// - Both configuration words reset to zero.
// - Offset bits 23:8 sit in the full upper offset register.
// - The assembled 24-bit offset is a signed two's complement value.
// - Offset bits 7:0 sit in lower register bits 15:8, whose low byte reads zero.
// - Gain bits 23:8 sit in the full upper gain register.
// - The 24-bit gain is unsigned with the top bit weighing one, below two.
// - Gain bits 7:0 sit in lower register bits 15:8, whose low byte reads zero.
// - The upper gain register resets to 8000h and the other calibration words to zero.
`timescale 1ns/100ps
`default_nettype none

module adc_channel_cal_cfg_regs #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic                      clock,
    input  wire logic                      resetn,
    input  wire logic [ADDR_W-1:0]         address,
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [31:0]               writedata,
    input  wire logic [3:0]                byteenable,
    output logic      [31:0]               readdata,
    output logic      [1:0]                response,
    output logic                           waitrequest,
    input  wire logic [3:0]                global_dc_removal_setting,
    output logic                           chan_a_dc_removal_active,
    output logic                           chan_b_dc_removal_active,
    output cal_cfg_pkg::chan_config_t      chan_a_config,
    output cal_cfg_pkg::chan_config_t      chan_b_config,
    output cal_cfg_pkg::chan_cal_t         chan_a_cal
);

    logic [15:0] cfg_a_q;
    logic [15:0] cfg_a_d;
    logic [15:0] cfg_b_q;
    logic [15:0] cfg_b_d;
    logic [15:0] off_hi_q;
    logic [15:0] off_hi_d;
    logic [15:0] off_lo_q;
    logic [15:0] off_lo_d;
    logic [15:0] gain_hi_q;
    logic [15:0] gain_hi_d;
    logic [15:0] gain_lo_q;
    logic [15:0] gain_lo_d;
    logic        done_q;
    logic        done_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  resp_q;
    logic [1:0]  resp_d;
    logic [5:0]  index;
    logic        mapped;
    logic [15:0] lane_mask;

    function automatic logic [15:0] merge(input logic [15:0] old_val,
                                          input logic [15:0] new_val,
                                          input logic [15:0] bit_mask);
        merge = (old_val & ~bit_mask) | (new_val & bit_mask);
    endfunction

    function automatic cal_cfg_pkg::chan_config_t unpack_cfg(input logic [15:0] word);
        unpack_cfg.phase_delay    = $signed(word[cal_cfg_pkg::PHASE_MSB:cal_cfg_pkg::PHASE_LSB]);
        unpack_cfg.dc_removal_off = word[cal_cfg_pkg::DC_OFF_BIT];
        unpack_cfg.input_select   =
            cal_cfg_pkg::input_select_t'(word[cal_cfg_pkg::SEL_MSB:cal_cfg_pkg::SEL_LSB]);
    endfunction

    // Register index is the word address; byte address bits 1:0 are ignored.
    assign index = address[7:2];
    assign lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

    always_comb
    begin
        unique case (index)
            cal_cfg_pkg::CHAN_A_CONFIG_IDX,
            cal_cfg_pkg::CHAN_A_OFFSET_UPPER_IDX,
            cal_cfg_pkg::CHAN_A_OFFSET_LOWER_IDX,
            cal_cfg_pkg::CHAN_A_GAIN_UPPER_IDX,
            cal_cfg_pkg::CHAN_A_GAIN_LOWER_IDX,
            cal_cfg_pkg::CHAN_B_CONFIG_IDX,
            cal_cfg_pkg::STATUS_IDX: mapped = 1'b1;
            default:                 mapped = 1'b0;
        endcase
    end

    // Each access is answered one cycle after it is presented.
    always_comb
    begin
        done_d = (read | write) & ~done_q;
        resp_d = resp_q;
        rdata_d = rdata_q;
        if ((read | write) & ~done_q)
        begin
            resp_d = mapped ? 2'h0 : 2'h2;
            rdata_d = 32'h0000_0000;
        end
        if (read & ~done_q)
        begin
            unique case (index)
                cal_cfg_pkg::CHAN_A_CONFIG_IDX:       rdata_d[15:0] = cfg_a_q;
                cal_cfg_pkg::CHAN_A_OFFSET_UPPER_IDX: rdata_d[15:0] = off_hi_q;
                cal_cfg_pkg::CHAN_A_OFFSET_LOWER_IDX: rdata_d[15:0] = off_lo_q;
                cal_cfg_pkg::CHAN_A_GAIN_UPPER_IDX:   rdata_d[15:0] = gain_hi_q;
                cal_cfg_pkg::CHAN_A_GAIN_LOWER_IDX:   rdata_d[15:0] = gain_lo_q;
                cal_cfg_pkg::CHAN_B_CONFIG_IDX:       rdata_d[15:0] = cfg_b_q;
                cal_cfg_pkg::STATUS_IDX:
                    rdata_d[1:0] = {chan_b_dc_removal_active, chan_a_dc_removal_active};
                default:                              rdata_d[15:0] = 16'h0000;
            endcase
        end
    end

    always_comb
    begin
        cfg_a_d = cfg_a_q;
        cfg_b_d = cfg_b_q;
        off_hi_d = off_hi_q;
        off_lo_d = off_lo_q;
        gain_hi_d = gain_hi_q;
        gain_lo_d = gain_lo_q;
        if (write & ~done_q)
        begin
            unique case (index)
                cal_cfg_pkg::CHAN_A_CONFIG_IDX:
                    cfg_a_d = merge(cfg_a_q, writedata[15:0],
                                    lane_mask & cal_cfg_pkg::CONFIG_MASK);
                cal_cfg_pkg::CHAN_B_CONFIG_IDX:
                    cfg_b_d = merge(cfg_b_q, writedata[15:0],
                                    lane_mask & cal_cfg_pkg::CONFIG_MASK);
                cal_cfg_pkg::CHAN_A_OFFSET_UPPER_IDX:
                    off_hi_d = merge(off_hi_q, writedata[15:0],
                                     lane_mask & cal_cfg_pkg::FULL_MASK);
                cal_cfg_pkg::CHAN_A_OFFSET_LOWER_IDX:
                    off_lo_d = merge(off_lo_q, writedata[15:0],
                                     lane_mask & cal_cfg_pkg::CAL_LOWER_MASK);
                cal_cfg_pkg::CHAN_A_GAIN_UPPER_IDX:
                    gain_hi_d = merge(gain_hi_q, writedata[15:0],
                                      lane_mask & cal_cfg_pkg::FULL_MASK);
                cal_cfg_pkg::CHAN_A_GAIN_LOWER_IDX:
                    gain_lo_d = merge(gain_lo_q, writedata[15:0],
                                      lane_mask & cal_cfg_pkg::CAL_LOWER_MASK);
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_a_q   <= cal_cfg_pkg::CONFIG_RESET;
            cfg_b_q   <= cal_cfg_pkg::CONFIG_RESET;
            off_hi_q  <= cal_cfg_pkg::OFFSET_UPPER_RESET;
            off_lo_q  <= cal_cfg_pkg::OFFSET_LOWER_RESET;
            gain_hi_q <= cal_cfg_pkg::GAIN_UPPER_RESET;
            gain_lo_q <= cal_cfg_pkg::GAIN_LOWER_RESET;
            done_q    <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            resp_q    <= 2'h0;
        end
        else
        begin
            cfg_a_q   <= cfg_a_d;
            cfg_b_q   <= cfg_b_d;
            off_hi_q  <= off_hi_d;
            off_lo_q  <= off_lo_d;
            gain_hi_q <= gain_hi_d;
            gain_lo_q <= gain_lo_d;
            done_q    <= done_d;
            rdata_q   <= rdata_d;
            resp_q    <= resp_d;
        end
    end

    assign waitrequest = (read | write) & ~done_q;
    assign readdata = rdata_q;
    assign response = resp_q;

    assign chan_a_config = unpack_cfg(cfg_a_q);
    assign chan_b_config = unpack_cfg(cfg_b_q);
    // The channel follows the global setting unless its own bypass bit is set.
    assign chan_a_dc_removal_active = ~cfg_a_q[cal_cfg_pkg::DC_OFF_BIT] &
                                      (|global_dc_removal_setting);
    assign chan_b_dc_removal_active = ~cfg_b_q[cal_cfg_pkg::DC_OFF_BIT] &
                                      (|global_dc_removal_setting);
    assign chan_a_cal.offset = $signed({off_hi_q, off_lo_q[15:cal_cfg_pkg::CAL_LOW_LSB]});
    // Gain word 800000h is unity; the range runs up to just under two.
    assign chan_a_cal.gain = {gain_hi_q, gain_lo_q[15:cal_cfg_pkg::CAL_LOW_LSB]};

    // Reset values, reserved bits and register updates are checked here.
    cfg_reset_zero_a: assert property (
        @(posedge clock)
        $rose(resetn)
        |-> cfg_a_q == 16'h0000 && cfg_b_q == 16'h0000)
        else $error("config words not zero after reset");

    gain_unity_reset_a: assert property (
        @(posedge clock)
        $rose(resetn)
        |-> chan_a_cal.gain == 24'h800000 && chan_a_cal.offset == 24'h000000)
        else $error("calibration reset value wrong");

    cfg_reserved_zero_a: assert property (
        @(posedge clock) disable iff (!resetn)
        cfg_a_q[5:3] == 3'h0
        && cfg_b_q[5:3] == 3'h0)
        else $error("config reserved bits set");

    cal_low_zero_a: assert property (
        @(posedge clock) disable iff (!resetn)
        off_lo_q[7:0] == 8'h00
        && gain_lo_q[7:0] == 8'h00)
        else $error("calibration low byte set");

    phase_a_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_A_CONFIG_IDX && byteenable == 4'hF
        |=> chan_a_config.phase_delay == $past(writedata[15:6]))
        else $error("channel a phase not written");

    phase_b_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_B_CONFIG_IDX && byteenable == 4'hF
        |=> chan_b_config.phase_delay == $past(writedata[15:6]) && $stable(cfg_a_q))
        else $error("channel b phase not independent");

    sel_a_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_A_CONFIG_IDX && byteenable[0]
        |=> chan_a_config.input_select == $past(writedata[1:0]))
        else $error("channel a select not written");

    sel_b_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_B_CONFIG_IDX && byteenable[0]
        |=> chan_b_config.input_select == $past(writedata[1:0]))
        else $error("channel b select not written");

    dc_bypass_a: assert property (
        @(posedge clock) disable iff (!resetn)
        cfg_a_q[2]
        |-> !chan_a_dc_removal_active)
        else $error("channel a dc removal not bypassed");

    dc_follow_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !cfg_b_q[2]
        |-> chan_b_dc_removal_active == (global_dc_removal_setting != 4'h0))
        else $error("channel b dc removal not following global");

    offset_hi_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_A_OFFSET_UPPER_IDX && byteenable == 4'hF
        |=> chan_a_cal.offset[23:8] == $past(writedata[15:0]))
        else $error("offset upper not written");

    gain_lo_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_A_GAIN_LOWER_IDX && byteenable == 4'hF
        |=> chan_a_cal.gain[7:0] == $past(writedata[15:8])
            && chan_a_cal.gain[23:8] == $past(chan_a_cal.gain[23:8]))
        else $error("gain lower not written");

    bus_answer_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (read || write) && !done_q
        |=> !waitrequest ##1 !done_q)
        else $error("bus answer not in one cycle");

    dc_bypass_b_a: assert property (
        @(posedge clock) disable iff (!resetn)
        cfg_b_q[2]
        |-> !chan_b_dc_removal_active)
        else $error("channel b dc removal not bypassed");

    dc_follow_chan_a_a: assert property (
        @(posedge clock) disable iff (!resetn)
        !cfg_a_q[2]
        |-> chan_a_dc_removal_active == (global_dc_removal_setting != 4'h0))
        else $error("channel a dc removal not following global");

    dc_off_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_A_CONFIG_IDX && byteenable[0]
        |=> chan_a_config.dc_removal_off == $past(writedata[2]))
        else $error("channel a bypass bit not written");

    offset_lo_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_A_OFFSET_LOWER_IDX && byteenable == 4'hF
        |=> chan_a_cal.offset[7:0] == $past(writedata[15:8]))
        else $error("offset lower not written");

    gain_hi_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_A_GAIN_UPPER_IDX && byteenable == 4'hF
        |=> chan_a_cal.gain[23:8] == $past(writedata[15:0]))
        else $error("gain upper not written");

    offset_sign_a: assert property (
        @(posedge clock) disable iff (!resetn)
        1'b1
        |-> chan_a_cal.offset[23] == off_hi_q[15])
        else $error("offset sign not from upper register");

    lane_off_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && index == cal_cfg_pkg::CHAN_A_CONFIG_IDX && byteenable[1:0] == 2'h0
        |=> $stable(cfg_a_q))
        else $error("disabled lanes written");

    unmapped_resp_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (read || write) && !done_q && !mapped
        |=> response == 2'h2 && readdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    unmapped_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && !mapped
        |=> $stable(cfg_a_q) && $stable(cfg_b_q) && $stable(off_hi_q) && $stable(gain_hi_q))
        else $error("unmapped write changed a register");

    read_upper_zero_a: assert property (
        @(posedge clock) disable iff (!resetn)
        (read || write) && !done_q
        |=> readdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");

    read_gain_a: assert property (
        @(posedge clock) disable iff (!resetn)
        read && !done_q && index == cal_cfg_pkg::CHAN_A_GAIN_UPPER_IDX
        |=> readdata[15:0] == $past(gain_hi_q))
        else $error("gain upper read wrong");

    unmapped_lo_write_a: assert property (
        @(posedge clock) disable iff (!resetn)
        write && !done_q && !mapped
        |=> $stable(off_lo_q) && $stable(gain_lo_q))
        else $error("unmapped write changed a lower register");

    // Main scenarios that the bench is expected to reach.
    write_cfg_c: cover property (@(posedge clock) disable iff (!resetn)
        write && !waitrequest && index == cal_cfg_pkg::CHAN_A_CONFIG_IDX);

    read_gain_c: cover property (@(posedge clock) disable iff (!resetn)
        read && !waitrequest && index == cal_cfg_pkg::CHAN_A_GAIN_UPPER_IDX);

    bypass_c: cover property (@(posedge clock) disable iff (!resetn) cfg_b_q[2]);

    unmapped_c: cover property (@(posedge clock) disable iff (!resetn)
        !waitrequest && response == 2'h2);

    status_read_c: cover property (@(posedge clock) disable iff (!resetn)
        read && !waitrequest && index == cal_cfg_pkg::STATUS_IDX);

endmodule

`default_nettype wire

/* dv/adc_channel_cal_cfg_regs_tb_top.sv */
// Self-checking testbench for the channel configuration and calibration registers.
// Assumes the register block answers on Avalon-MM and needs no partner model.
`timescale 1ns/100ps
`default_nettype none

module adc_channel_cal_cfg_regs_tb_top;
    logic                      clock = 1'b0;
    logic                      resetn = 1'b0;
    logic [7:0]                address = 8'h00;
    logic                      read = 1'b0;
    logic                      write = 1'b0;
    logic [31:0]               writedata = 32'h0;
    logic [3:0]                byteenable = 4'h0;
    logic [31:0]               readdata;
    logic [1:0]                response;
    logic                      waitrequest;
    logic [3:0]                global_dc_removal_setting = 4'h0;
    logic                      chan_a_dc_removal_active;
    logic                      chan_b_dc_removal_active;
    cal_cfg_pkg::chan_config_t chan_a_config;
    cal_cfg_pkg::chan_config_t chan_b_config;
    cal_cfg_pkg::chan_cal_t    chan_a_cal;
    int                        errors = 0;
    int                        checks = 0;

    always #4 clock = ~clock;

    adc_channel_cal_cfg_regs #(.ADDR_W(8)) dut (.clock(clock), .resetn(resetn),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata), .response(response),
        .waitrequest(waitrequest), .global_dc_removal_setting(global_dc_removal_setting),
        .chan_a_dc_removal_active(chan_a_dc_removal_active),
        .chan_b_dc_removal_active(chan_b_dc_removal_active),
        .chan_a_config(chan_a_config), .chan_b_config(chan_b_config), .chan_a_cal(chan_a_cal));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // One Avalon transfer; the request is held until waitrequest is seen low.
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
                        input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rsp);
        address    <= {idx, 2'b00};
        writedata  <= {16'h0000, wd};
        byteenable <= be;
        write      <= wr;
        read       <= ~wr;
        do @(posedge clock); while (waitrequest !== 1'b0);
        rd  = readdata;
        rsp = response;
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [15:0] wd, input logic [3:0] be);
        logic [31:0] rd;
        logic [1:0]  rsp;
        xfer(1'b1, idx, wd, be, rd, rsp);
    endtask

    task automatic rdchk(input logic [5:0] idx, input logic [15:0] exp, input logic [1:0] er);
        logic [31:0] rd;
        logic [1:0]  rsp;
        xfer(1'b0, idx, 16'h0000, 4'hF, rd, rsp);
        check(rd, {16'h0000, exp}, "read data");
        check({30'h0, rsp}, {30'h0, er}, "response");
    endtask

    task automatic t_reset;
        logic [15:0] rv [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
        for (int i = 0; i < 6; i++)
            rdchk(6'h18 + 6'(i), rv[i], 2'b00);
        check({19'h0, chan_a_config}, 32'h0, "config a reset");
        check({19'h0, chan_b_config}, 32'h0, "config b reset");
        check(chan_a_cal[31:0], 32'h00800000, "cal reset");
        wr(6'h20, 16'hFFFF, 4'hF);
        rdchk(6'h20, 16'h0000, 2'b10);
        $display("test reset done");
    endtask

    task automatic t_masks;
        logic [15:0] mv [6] = '{16'hFFC7, 16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFF00, 16'hFFC7};
        for (int i = 0; i < 6; i++)
            wr(6'h18 + 6'(i), 16'hFFFF, 4'hF);
        for (int i = 0; i < 6; i++)
            rdchk(6'h18 + 6'(i), mv[i], 2'b00);
        check({19'h0, chan_a_config}, 32'h1FFF, "config a ones");
        check({8'h0, chan_a_cal.offset}, 32'h00FFFFFF, "offset ones");
        $display("test masks done");
    endtask

    task automatic t_fields;
        for (int i = 0; i < 4; i++)
        begin
            wr(6'h18, {10'h201, 3'b000, 1'b0, 2'(i)}, 4'h3);
            wr(6'h1D, {10'h1FE, 3'b111, 1'b1, 2'(3 - i)}, 4'h3);
            check({19'h0, chan_a_config}, {19'h0, 10'h201, 1'b0, 2'(i)}, "config a");
            check({19'h0, chan_b_config}, {19'h0, 10'h1FE, 1'b1, 2'(3 - i)}, "config b");
        end
        $display("test fields done");
    endtask

    task automatic t_dc;
        logic [3:0] gv [4] = '{4'h0, 4'h1, 4'h8, 4'hF};
        for (int i = 0; i < 4; i++)
        begin
            global_dc_removal_setting <= gv[i];
            @(negedge clock);
            check({31'h0, chan_a_dc_removal_active}, {31'h0, gv[i] != 4'h0}, "dc a");
            check({31'h0, chan_b_dc_removal_active}, 32'h0, "dc b off");
            @(posedge clock);
        end
        wr(6'h18, 16'h0004, 4'h3);
        wr(6'h1D, 16'h0000, 4'h3);
        @(negedge clock);
        check({31'h0, chan_a_dc_removal_active}, 32'h0, "dc a off");
        check({31'h0, chan_b_dc_removal_active}, 32'h1, "dc b on");
        @(posedge clock);
        rdchk(6'h30, 16'h0002, 2'b00);
        $display("test dc removal done");
    endtask

    task automatic t_cal;
        wr(6'h19, 16'h8123, 4'h3);
        wr(6'h1A, 16'hA5FF, 4'h3);
        wr(6'h1B, 16'h4000, 4'h3);
        wr(6'h1C, 16'h7E3C, 4'h3);
        rdchk(6'h1A, 16'hA500, 2'b00);
        check({8'h0, chan_a_cal.offset}, 32'h008123A5, "offset value");
        check({8'h0, chan_a_cal.gain}, 32'h0040007E, "gain value");
        wr(6'h1B, 16'h1234, 4'h1);
        rdchk(6'h1B, 16'h4034, 2'b00);
        $display("test calibration done");
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_reset();
        t_masks();
        t_fields();
        t_dc();
        t_cal();
        results();
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        errors++;
        results();
    end
endmodule

`default_nettype wire
